// ---- bench/cssp_clock_ctrl_props.sv ----
module cssp_clock_ctrl_props (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic [31:0] prdata,
  input wire logic pslverr,
  // config and outputs
  input wire cssp_pkg::cssp_clock_select_field_t fuseCfg,
  input wire logic [7:0] factoryTrim,
  input wire logic sleepReq,
  input wire logic [7:0] rcTrim,
  input wire logic rcOn,
  input wire logic pllRun,
  input wire logic [3:0] pllFactor,
  input wire logic cpuRun,
  input wire logic clkOut,
  input wire logic clkOutOeN
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);
  property p_oe_reset;
    $past(rst) |-> clkOutOeN && !clkOut;
  endproperty
  a_oe_reset: assert property (p_oe_reset) else $error("pin driven after reset");
  property p_quiet;
    clkOutOeN |-> !clkOut;
  endproperty
  a_quiet: assert property (p_quiet) else $error("clock on released pin");
  property p_sleep;
    sleepReq && cpuRun |=> !cpuRun && !rcOn && !pllRun;
  endproperty
  a_sleep: assert property (p_sleep) else $error("sleep left clocks on");
  property p_wait;
    psel && $rose(penable) |-> !pready ##1 pready;
  endproperty
  a_wait: assert property (p_wait) else $error("wait state wrong");
  property p_pulse;
    pready |=> !pready;
  endproperty
  a_pulse: assert property (p_pulse) else $error("ready too long");
  property p_refuse;
    pready && pslverr |-> prdata == 32'h00000000;
  endproperty
  a_refuse: assert property (p_refuse) else $error("refused read data");
  property p_trim;
    $past(rst, 2) && !$past(rst) |-> rcTrim == $past(factoryTrim);
  endproperty
  a_trim: assert property (p_trim) else $error("trim not loaded");
  property p_fact;
    $past(rst, 2) && !$past(rst) |-> pllFactor == (($past(fuseCfg.clock_select_field) inside {4'h1, 4'h4, 4'h5}) ?
      cssp_pkg::FACT_PLL : cssp_pkg::FACT_OTHER);
  endproperty
  a_fact: assert property (p_fact) else $error("factor default");
  property p_pll;
    psel && penable && pready && pwrite && paddr == cssp_pkg::OFS_PLLCS && cpuRun && !sleepReq
      |=> ##1 pllRun == $past(pwdata[0], 2);
  endproperty
  a_pll: assert property (p_pll) else $error("pll enable ignored");
endmodule : cssp_clock_ctrl_props

bind cssp_clock_ctrl cssp_clock_ctrl_props u_props (.core_clk, .rst, .psel, .penable, .pwrite, .paddr,
  .pwdata, .pready, .prdata, .pslverr, .fuseCfg, .factoryTrim, .sleepReq, .rcTrim, .rcOn, .pllRun,
  .pllFactor, .cpuRun, .clkOut, .clkOutOeN);

// ---- bench/cssp_clock_ctrl_tb_top.sv ----
module cssp_clock_ctrl_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h00000000;
  cssp_pkg::cssp_clock_select_field_t fuseCfg = '{clock_out_bit: 1'b1, startup_code_field: 2'h0, clock_select_field: 4'h3};
  logic [7:0] factoryTrim = 8'h5A;
  logic sleepReq = 1'b0;
  logic wakeReq = 1'b0;
  logic pready, pslverr, rcOn, pllRun, cpuRun, clkOut, clkOutOeN, irq, sysTick, er, t0;
  logic [31:0] prdata, rd;
  logic [7:0] rcTrim;
  logic [3:0] pllFactor, srcTick;
  int fails = 0;
  int samples_checked = 0;
  always #12.5 core_clk = !core_clk;
  cssp_clock_ctrl dut (.core_clk(core_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr), .fuseCfg(fuseCfg),
    .factoryTrim(factoryTrim), .srcTick(srcTick), .sysTick(sysTick), .sleepReq(sleepReq), .wakeReq(wakeReq),
    .rcTrim(rcTrim), .rcOn(rcOn), .pllRun(pllRun), .pllFactor(pllFactor), .cpuRun(cpuRun), .clkOut(clkOut),
    .clkOutOeN(clkOutOeN), .irq(irq));
  cssp_src_model model (.core_clk(core_clk), .rcOn(rcOn), .srcTick(srcTick), .sysTick(sysTick));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: %s got %h exp %h", $time, msg, got, exp);
    end
  endtask : chk
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do begin
      @(posedge core_clk);
      n++;
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    chk(32'(n), 32'h00000002, "wait states");
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic waitHi(input int which, input int lim);
    int n;
    n = 0;
    while (((which == 0) ? cpuRun : irq) !== 1'b1 && n < lim) begin
      @(posedge core_clk);
      n++;
    end
    chk(32'(n < lim), 32'h00000001, "wait ran out");
  endtask : waitHi
  task automatic end_sim;
    $display("checked %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : end_sim
  initial begin
    repeat (20000) @(posedge core_clk);
    fails++;
    end_sim();
  end
  initial begin
    repeat (5) @(posedge core_clk);
    rst <= 1'b0;
    waitHi(0, 80);
    chk(32'(rcTrim), 32'h0000005A, "trim");
    chk(32'(pllFactor), 32'h00000000, "factor");
    chk(32'(rcOn), 32'h00000000, "rc on");
    chk(32'(clkOutOeN), 32'h00000000, "pin enable");
    t0 = clkOut;
    repeat (2) @(posedge core_clk);
    chk(32'(clkOut), 32'(!t0), "clock out");
    apb(1'b0, cssp_pkg::OFS_CLKSEL, 32'h00000000);
    chk(rd, 32'h00000043, "select latch");
    chk(32'(irq), 32'h00000000, "masked irq");
    apb(1'b1, cssp_pkg::OFS_IRQMSK, 32'h00000003);
    @(posedge core_clk);
    chk(32'(irq), 32'h00000001, "start irq");
    apb(1'b0, cssp_pkg::OFS_IRQST, 32'h00000000);
    chk(rd, 32'h00000001, "start status");
    apb(1'b0, cssp_pkg::OFS_IRQST, 32'h00000000);
    chk(rd, 32'h00000000, "status clear");
    apb(1'b1, cssp_pkg::OFS_PLLCS, 32'h00000061);
    repeat (2) @(posedge core_clk);
    chk(32'(pllRun), 32'h00000001, "pll run");
    chk(32'(pllFactor), 32'h00000006, "factor write");
    waitHi(1, 4100);
    apb(1'b0, cssp_pkg::OFS_PLLCS, 32'h00000000);
    chk(rd, 32'h00000063, "lock flag");
    apb(1'b0, cssp_pkg::OFS_IRQST, 32'h00000000);
    chk(rd, 32'h00000002, "lock status");
    apb(1'b0, 8'h40, 32'h00000000);
    chk({31'h0, er}, 32'h00000001, "unmapped err");
    chk(rd, 32'h00000000, "unmapped data");
    sleepReq <= 1'b1;
    @(posedge core_clk);
    sleepReq <= 1'b0;
    @(posedge core_clk);
    chk({29'h0, cpuRun, rcOn, pllRun}, 32'h00000000, "sleep");
    wakeReq <= 1'b1;
    @(posedge core_clk);
    wakeReq <= 1'b0;
    waitHi(0, 40);
    $display("test one done");
    rst <= 1'b1;
    fuseCfg <= '{clock_out_bit: 1'b0, startup_code_field: 2'h1, clock_select_field: 4'h4};
    factoryTrim <= 8'hA5;
    repeat (5) @(posedge core_clk);
    rst <= 1'b0;
    repeat (3) @(posedge core_clk);
    chk(32'(pllFactor), 32'h00000006, "pll factor");
    chk(32'(rcTrim), 32'h000000A5, "trim again");
    chk(32'(clkOutOeN), 32'h00000001, "pin off");
    repeat (1480) @(posedge core_clk);
    chk(32'(cpuRun), 32'h00000000, "early run");
    waitHi(0, 200);
    $display("test two done");
    rst <= 1'b1;
    fuseCfg <= '{clock_out_bit: 1'b0, startup_code_field: 2'h2, clock_select_field: 4'hE};
    repeat (5) @(posedge core_clk);
    rst <= 1'b0;
    apb(1'b0, cssp_pkg::OFS_CLKSEL, 32'h00000000);
    chk(rd, 32'h0000002E, "crystal latch");
    chk(32'(pllFactor), 32'h00000000, "crystal factor");
    chk(32'(rcOn), 32'h00000001, "crystal rc");
    repeat (1026) @(posedge core_clk);
    chk(32'(cpuRun), 32'h00000000, "crystal early");
    waitHi(0, 20);
    $display("test three done");
    end_sim();
  end
endmodule : cssp_clock_ctrl_tb_top

// ---- bench/cssp_src_model.sv ----
module cssp_src_model (
  // clock and rc enable
  input wire logic core_clk,
  input wire logic rcOn,
  // source ticks
  output logic [3:0] srcTick,
  output logic sysTick
);
  timeunit 1ns;
  timeprecision 1ps;
  initial srcTick = 4'h0;
  initial sysTick = 1'b0;
  always @(posedge core_clk) begin
    srcTick <= {3'h7, rcOn};
    sysTick <= !sysTick;
  end
endmodule : cssp_src_model

// ---- logic/cssp_clock_ctrl.sv ----
module cssp_clock_ctrl (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  // fuses and signature row
  input wire cssp_pkg::cssp_clock_select_field_t fuseCfg,
  input wire logic [7:0] factoryTrim,
  // source cycle ticks, one per source cycle
  input wire logic [3:0] srcTick,
  input wire logic sysTick,
  // sleep control
  input wire logic sleepReq,
  input wire logic wakeReq,
  // oscillator and pll control
  output logic [7:0] rcTrim,
  output logic rcOn,
  output logic pllRun,
  output logic [3:0] pllFactor,
  output logic cpuRun,
  // clock output pin
  output logic clkOut,
  output logic clkOutOeN,
  // interrupt
  output logic irq
);

  cssp_pkg::cssp_state_t q;
  cssp_pkg::cssp_state_t d;

  function automatic cssp_pkg::cssp_sut_t sutLook(input cssp_pkg::cssp_clock_select_field_t c);
    cssp_pkg::cssp_sut_t s;
    s.src = cssp_pkg::SRC_RC;
    s.wake = cssp_pkg::CK_6;
    // RULE_03 startup_code_field extension table
    unique case (c.startup_code_field)
      2'h0: s.ext = cssp_pkg::EXT_NONE;
      2'h1: s.ext = cssp_pkg::EXT_4MS;
      default: s.ext = cssp_pkg::EXT_64MS;
    endcase
    if (c.clock_select_field[3]) begin
      // RULE_04 crystal modes 100..111
      s.src = cssp_pkg::SRC_XT;
      // RULE_05 crystal delay table
      unique case ({c.clock_select_field[0], c.startup_code_field})
        3'h0: begin
          s.wake = cssp_pkg::CK_258;
          s.ext = cssp_pkg::EXT_4MS;
        end
        3'h1: begin
          s.wake = cssp_pkg::CK_258;
          s.ext = cssp_pkg::EXT_64MS;
        end
        3'h2: begin
          s.wake = cssp_pkg::CK_1K;
          s.ext = cssp_pkg::EXT_NONE;
        end
        3'h3: begin
          s.wake = cssp_pkg::CK_1K;
          s.ext = cssp_pkg::EXT_4MS;
        end
        3'h4: begin
          s.wake = cssp_pkg::CK_1K;
          s.ext = cssp_pkg::EXT_64MS;
        end
        3'h5: begin
          s.wake = cssp_pkg::CK_16K;
          s.ext = cssp_pkg::EXT_NONE;
        end
        3'h6: begin
          s.wake = cssp_pkg::CK_16K;
          s.ext = cssp_pkg::EXT_4MS;
        end
        default: begin
          s.wake = cssp_pkg::CK_16K;
          s.ext = cssp_pkg::EXT_64MS;
        end
      endcase
    end else begin
      unique case (c.clock_select_field)
        // RULE_06 external clock
        4'h0: s.src = cssp_pkg::SRC_EX;
        // RULE_02 128k source
        4'h3: s.src = cssp_pkg::SRC_WD;
        // RULE_13 pll on crystal
        4'h4: begin
          s.src = cssp_pkg::SRC_XT;
          s.wake = (c.startup_code_field == 2'h3) ? cssp_pkg::CK_16K : cssp_pkg::CK_1K;
          if (c.startup_code_field == 2'h3) begin
            s.ext = cssp_pkg::EXT_NONE;
          end
        end
        // RULE_13 pll on external clock
        4'h5: begin
          s.src = cssp_pkg::SRC_EX;
          s.wake = cssp_pkg::CK_16K;
          if (c.startup_code_field == 2'h2) begin
            s.ext = cssp_pkg::EXT_4MS;
          end
        end
        // RULE_13 pll on rc
        4'h1: s.wake = cssp_pkg::CK_1K;
        default: s.wake = cssp_pkg::CK_6;
      endcase
    end
    return s;
  endfunction : sutLook

  function automatic logic isPllSel(input logic [3:0] c);
    return (c == 4'h1) || (c == 4'h4) || (c == 4'h5);
  endfunction : isPllSel

  always_comb begin
    cssp_pkg::cssp_sut_t sut;
    logic tick;
    logic [14:0] target;
    logic [14:0] extCyc;
    logic [31:0] rd;
    logic hit;
    logic done;
    logic sleeping;
    logic [1:0] ev;
    d = q;
    sut = sutLook(q.cfg);
    // RULE_19 count on the selected source
    tick = srcTick[sut.src];
    target = q.inReset ? 15'(sut.wake + cssp_pkg::CK_RST) : sut.wake;
    // RULE_18 watchdog-timed extension
    extCyc = (sut.ext == cssp_pkg::EXT_64MS) ? cssp_pkg::WD_64MS : cssp_pkg::WD_4MS;
    ev = 2'h0;
    done = psel && penable && q.pready;
    rd = 32'h0000_0000;
    hit = 1'b1;
    unique case (paddr)
      cssp_pkg::OFS_CLKSEL: rd[6:0] = q.cfg;
      cssp_pkg::OFS_PLLCS: begin
        rd[cssp_pkg::POS_PLLEN] = q.pllEn;
        rd[cssp_pkg::POS_PLL_LOCK_FLAG] = q.lock;
        rd[cssp_pkg::POS_FACT +: 4] = q.fact;
      end
      cssp_pkg::OFS_TRIM: rd[7:0] = q.trim;
      cssp_pkg::OFS_IRQST: rd[1:0] = q.irqSt;
      cssp_pkg::OFS_IRQMSK: rd[1:0] = q.irqMsk;
      cssp_pkg::OFS_STATUS: rd[7:0] = {q.st, q.inReset, q.rcOn, q.cpuRun};
      default: hit = 1'b0;
    endcase
    // one wait state, then answer held until the sampling edge
    d.pready = psel && penable && !q.pready;
    if (d.pready) begin
      d.prdata = rd;
      d.pslverr = !hit;
    end
    if (done && pwrite && hit) begin
      unique case (paddr)
        // RULE_17 register stands in for fuses
        cssp_pkg::OFS_CLKSEL: d.cfg = pwdata[6:0];
        // RULE_11 software-set factor
        cssp_pkg::OFS_PLLCS: begin
          d.pllEn = pwdata[cssp_pkg::POS_PLLEN];
          d.fact = pwdata[cssp_pkg::POS_FACT +: 4];
        end
        cssp_pkg::OFS_TRIM: d.trim = pwdata[7:0];
        cssp_pkg::OFS_IRQMSK: d.irqMsk = pwdata[1:0];
        default: d.cfg = q.cfg;
      endcase
    end
    if (done && !pwrite && paddr == cssp_pkg::OFS_IRQST) begin
      d.irqSt = 2'h0;
    end
    unique case (q.st)
      cssp_pkg::ST_LOAD: begin
        // RULE_17 latch fuses after reset
        d.cfg = fuseCfg;
        // RULE_01 load factory trim
        d.trim = factoryTrim;
        // RULE_10 default factor for pll
        d.fact = isPllSel(fuseCfg.clock_select_field) ? cssp_pkg::FACT_PLL : cssp_pkg::FACT_OTHER;
        d.cnt = 15'h0000;
        d.st = cssp_pkg::ST_SRC;
      end
      cssp_pkg::ST_SRC: begin
        // RULE_19 hold execution for source count
        if (tick) begin
          if (15'(q.cnt + 15'h0001) >= target) begin
            d.cnt = 15'h0000;
            if (q.inReset && sut.ext != cssp_pkg::EXT_NONE) begin
              d.st = cssp_pkg::ST_WD;
            end else begin
              d.st = cssp_pkg::ST_RUN;
            end
          end else begin
            d.cnt = 15'(q.cnt + 15'h0001);
          end
        end
      end
      cssp_pkg::ST_WD: begin
        // RULE_18 512 or 8192 watchdog cycles
        if (srcTick[cssp_pkg::SRC_WD]) begin
          if (15'(q.cnt + 15'h0001) >= extCyc) begin
            d.cnt = 15'h0000;
            d.st = cssp_pkg::ST_RUN;
          end else begin
            d.cnt = 15'(q.cnt + 15'h0001);
          end
        end
      end
      cssp_pkg::ST_RUN: begin
        if (sleepReq) begin
          d.st = cssp_pkg::ST_SLEEP;
        end
      end
      cssp_pkg::ST_SLEEP: begin
        if (wakeReq) begin
          d.cnt = 15'h0000;
          d.st = cssp_pkg::ST_SRC;
        end
      end
      default: d.st = cssp_pkg::ST_LOAD;
    endcase
    if (d.st == cssp_pkg::ST_RUN && q.st != cssp_pkg::ST_RUN) begin
      d.inReset = 1'b0;
      ev[cssp_pkg::IRQ_START] = 1'b1;
    end
    d.cpuRun = (d.st == cssp_pkg::ST_RUN);
    sleeping = (d.st == cssp_pkg::ST_SLEEP);
    // RULE_12 rc off in deep sleep or with select codes 3, 4, 5, C, D
    d.rcOn = !sleeping && !(d.cfg.clock_select_field inside {4'h3, 4'h4, 4'h5, 4'hC, 4'hD});
    // RULE_08 pll gated by enable bit
    // RULE_12 pll off in deep sleep
    d.pllRun = d.pllEn && !sleeping;
    // RULE_07 lock timer counts core_clk cycles, whatever the reference
    // RULE_09 lock flag after lock time
    if (q.pllRun) begin
      if (q.lockCnt == 12'(cssp_pkg::LOCK_CYC - 12'h001)) begin
        d.lock = 1'b1;
        ev[cssp_pkg::IRQ_LOCK] = !q.lock;
      end else begin
        d.lockCnt = 12'(q.lockCnt + 12'h001);
      end
    end else begin
      d.lockCnt = 12'h000;
      d.lock = 1'b0;
    end
    // set wins over read-clear
    d.irqSt = d.irqSt | ev;
    d.irq = |(d.irqSt & d.irqMsk);
    // RULE_14 pin driven only when enabled
    // RULE_15 quiet during reset, overrides gpio
    d.clkOutOeN = !(d.cfg.clock_out_bit && !d.inReset);
    // RULE_16 follows the prescaled clock tick
    if (d.clkOutOeN) begin
      d.clkOut = 1'b0;
    end else if (sysTick) begin
      d.clkOut = !q.clkOut;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      q <= cssp_pkg::CSSP_RST;
    end else begin
      q <= d;
    end
  end

  assign pready = q.pready;
  assign prdata = q.prdata;
  assign pslverr = q.pslverr;
  assign rcTrim = q.trim;
  assign rcOn = q.rcOn;
  assign pllRun = q.pllRun;
  assign pllFactor = q.fact;
  assign cpuRun = q.cpuRun;
  assign clkOut = q.clkOut;
  assign clkOutOeN = q.clkOutOeN;
  assign irq = q.irq;

endmodule : cssp_clock_ctrl

// ---- shared/cssp_pkg.sv ----
// How it works
// RULE_01: reset copies factory trim byte into the RC trim register.
// RULE_02: 128kHz low-power oscillator selectable as system clock via fuses or field.
// RULE_03: 128kHz start-up: 6 cycles wake, 14 extra on reset, plus 4ms/64ms.
// RULE_04: crystal mode follows upper three select bits: 100,101,110,111 ranges.
// RULE_05: crystal: select bit 0 plus start-up code pick 258/1K/16K and extension.
// RULE_06: external clock: 6 cycles wake, 14 extra on reset, plus 4ms/64ms.
// RULE_07: PLL multiplies a nominal 8MHz reference from RC, crystal or external clock.
// RULE_08: PLL runs only while the PLL enable bit is set.
// RULE_09: lock flag sets once the PLL has locked.
// RULE_10: PLL multiplication factor starts at 6 when fuses select the PLL.
// RULE_11: software sets the PLL frequency factor itself.
// RULE_12: RC oscillator and PLL stop in power-down and standby.
// RULE_13: PLL as system clock: codes 0100, 0101, 0001 give their tabulated delays.
// RULE_14: clock drives the output pin only when clock-out fuse or bit is set.
// RULE_15: clock-out pin quiet during reset and overrides its general I/O use.
// RULE_16: clock-out pin carries the prescaled system clock.
// RULE_17: reset latches fuses into the clock-select register, which then stands in.
// RULE_18: reset extension counts 512 or 8192 watchdog oscillator cycles.
// RULE_19: cycle counts use the selected source; execution waits for all delays.
package cssp_pkg;
  // register byte offsets
  localparam logic [7:0] OFS_CLKSEL = 8'h00;
  localparam logic [7:0] OFS_PLLCS = 8'h04;
  localparam logic [7:0] OFS_TRIM = 8'h08;
  localparam logic [7:0] OFS_IRQST = 8'h0C;
  localparam logic [7:0] OFS_IRQMSK = 8'h10;
  localparam logic [7:0] OFS_STATUS = 8'h14;
  // field positions
  localparam int POS_PLLEN = 0;
  localparam int POS_PLL_LOCK_FLAG = 1;
  localparam int POS_FACT = 4;
  localparam int IRQ_START = 0;
  localparam int IRQ_LOCK = 1;
  // reset values
  localparam logic [3:0] FACT_PLL = 4'h6;
  localparam logic [3:0] FACT_OTHER = 4'h0;
  localparam logic [1:0] IRQMSK_RST = 2'h0;
  // start-up counts in cycles
  localparam logic [14:0] CK_6 = 15'h0006;
  localparam logic [14:0] CK_258 = 15'h0102;
  localparam logic [14:0] CK_1K = 15'h0400;
  localparam logic [14:0] CK_16K = 15'h4000;
  localparam logic [14:0] CK_RST = 15'h000E;
  localparam logic [14:0] WD_4MS = 15'h0200;
  localparam logic [14:0] WD_64MS = 15'h2000;
  // pll lock time
  localparam int CLK_HZ = 40_000_000;
  localparam int LOCK_US = 100;
  localparam logic [11:0] LOCK_CYC = 12'((LOCK_US * (CLK_HZ / 1_000_000)));
  // source tick indices
  localparam logic [1:0] SRC_RC = 2'h0;
  localparam logic [1:0] SRC_WD = 2'h1;
  localparam logic [1:0] SRC_XT = 2'h2;
  localparam logic [1:0] SRC_EX = 2'h3;
  // reset extension kinds
  localparam logic [1:0] EXT_NONE = 2'h0;
  localparam logic [1:0] EXT_4MS = 2'h1;
  localparam logic [1:0] EXT_64MS = 2'h2;

  typedef struct packed {
    logic clock_out_bit;
    logic [1:0] startup_code_field;
    logic [3:0] clock_select_field;
  } cssp_clock_select_field_t;

  typedef struct packed {
    logic [1:0] src;
    logic [1:0] ext;
    logic [14:0] wake;
  } cssp_sut_t;

  typedef enum logic [4:0] {
    ST_LOAD = 5'h01,
    ST_SRC = 5'h02,
    ST_WD = 5'h04,
    ST_RUN = 5'h08,
    ST_SLEEP = 5'h10
  } cssp_st_t;

  typedef struct packed {
    cssp_st_t st;
    logic inReset;
    logic [14:0] cnt;
    cssp_clock_select_field_t cfg;
    logic [7:0] trim;
    logic pllEn;
    logic [3:0] fact;
    logic pllRun;
    logic [11:0] lockCnt;
    logic lock;
    logic [1:0] irqSt;
    logic [1:0] irqMsk;
    logic irq;
    logic cpuRun;
    logic rcOn;
    logic clkOut;
    logic clkOutOeN;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } cssp_state_t;

  localparam cssp_state_t CSSP_RST = '{st: ST_LOAD, inReset: 1'b1, clkOutOeN: 1'b1, default: '0};
endpackage : cssp_pkg
